/* src/mpcs_host.v */
// Host controller issuing ordered media pipe commands to the device.
// Assumes APB from software and a valid/ready command port to the device.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "mpcs_map.vh"
module mpcs_host
(
  input  wire        clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output wire        cmd_valid,
  output wire [3:0]  cmd_op,
  output wire [27:0] cmd_arg,
  input  wire        cmd_ready,
  input  wire        seq_error
);
  localparam S_IDLE   = 4'h0;
  localparam S_FLUSH  = 4'h1;
  localparam S_SELECT = 4'h2;
  localparam S_BASE   = 4'h3;
  localparam S_SYSRT  = 4'h4;
  localparam S_FECFG  = 4'h5;
  localparam S_CURBE  = 4'h6;
  localparam S_IDLOAD = 4'h7;
  localparam S_GATE   = 4'h8;
  localparam S_PERS   = 4'h9;
  localparam S_FENCE  = 4'hA;
  localparam S_ARBOFF = 4'hB;
  localparam S_WORK   = 4'hC;
  localparam S_ARBON  = 4'hD;
  localparam S_DONE   = 4'hE;

  reg  [31:0] ctrl_q;
  reg  [15:0] group_q;
  reg  [15:0] count_q;
  reg  [27:0] sysrt_q;
  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [15:0] left_q;
  reg         err_q;
  reg         done_q;
  reg         load;
  reg  [3:0]  op;
  reg  [27:0] arg;
  wire        busy;
  wire        apb_wr;
  wire        apb_rd;
  wire        mapped;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign mapped = (paddr == `MPCS_OFF_CTRL) || (paddr == `MPCS_OFF_STATUS) ||
                  (paddr == `MPCS_OFF_GROUP) || (paddr == `MPCS_OFF_COUNT) ||
                  (paddr == `MPCS_OFF_SYSRT);

  // Zero wait state slave; read data set up during the setup cycle
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (apb_rd)
      begin
        case (paddr)
          `MPCS_OFF_CTRL:   prdata <= ctrl_q;
          `MPCS_OFF_STATUS: prdata <= {24'h00_0000, err_q, done_q, state_q != S_IDLE,
                                       state_q, busy};
          `MPCS_OFF_GROUP:  prdata <= {16'h0000, group_q};
          `MPCS_OFF_COUNT:  prdata <= {16'h0000, left_q};
          `MPCS_OFF_SYSRT:  prdata <= {4'h0, sysrt_q};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire wr_now = apb_wr && pready;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q  <= `MPCS_CTRL_RESET;
      group_q <= 16'h0000;
      count_q <= 16'h0000;
      sysrt_q <= 28'h000_0000;
    end
    else if (wr_now)
    begin
      case (paddr)
        `MPCS_OFF_CTRL:  ctrl_q  <= pwdata;
        `MPCS_OFF_GROUP: group_q <= pwdata[15:0];
        `MPCS_OFF_COUNT: count_q <= pwdata[15:0];
        `MPCS_OFF_SYSRT: sysrt_q <= pwdata[27:0];
        default:         ctrl_q  <= ctrl_q;
      endcase
    end
    else if (state_q == S_FLUSH)
      ctrl_q[`MPCS_CTRL_START] <= 1'b0;
  end

  wire start    = ctrl_q[`MPCS_CTRL_START];
  wire barrier  = ctrl_q[`MPCS_CTRL_BARRIER];
  // Synchronized items need arbitration off even outside a barrier group
  wire sync     = ctrl_q[`MPCS_CTRL_SYNC];
  wire sent     = !busy;

  // Sequencer: one command issued per state from S_FLUSH to S_ARBON (none in S_IDLE or S_DONE), one per work item in S_WORK; advance once output is free
  always @*
  begin
    state_d = state_q;
    load    = 1'b0;
    op      = 4'h0;
    arg     = 28'h000_0000;
    case (state_q)
      S_IDLE:
        if (start)
          state_d = S_FLUSH;
      S_FLUSH:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_FLUSH;
          state_d = ctrl_q[`MPCS_CTRL_SELECT] ? S_SELECT : S_BASE;
        end
      S_SELECT:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_SELECT;
          state_d = S_BASE;
        end
      S_BASE:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_BASE;
          state_d = ctrl_q[`MPCS_CTRL_SYSRT] ? S_SYSRT : S_FECFG;
        end
      S_SYSRT:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_SYSRT;
          arg     = sysrt_q;
          state_d = S_FECFG;
        end
      S_FECFG:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_FECFG;
          state_d = ctrl_q[`MPCS_CTRL_CURBE] ? S_CURBE : S_IDLOAD;
        end
      S_CURBE:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_CURBE;
          state_d = S_IDLOAD;
        end
      S_IDLOAD:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_IDLOAD;
          state_d = barrier ? S_GATE : (sync ? S_ARBOFF : S_WORK);
        end
      S_GATE:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_GATEWAY;
          arg     = {12'h000, group_q};
          state_d = S_PERS;
        end
      S_PERS:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_PERSIST;
          arg[`MPCS_FLAG_FEFLUSH] = 1'b1;
          arg[`MPCS_FLAG_PERSIST] = 1'b1;
          state_d = S_FENCE;
        end
      S_FENCE:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_FENCE;
          arg     = {11'h000, ctrl_q[`MPCS_CTRL_DEP], group_q};
          state_d = S_ARBOFF;
        end
      S_ARBOFF:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_ARB;
          arg     = 28'h000_0000;
          state_d = S_WORK;
        end
      S_WORK:
        if (left_q == 16'h0000)
          state_d = (barrier || sync) ? S_ARBON : S_DONE;
        else if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_WORK;
          arg     = {11'h000, sync, left_q};
        end
      S_ARBON:
        if (sent)
        begin
          load    = 1'b1;
          op      = `MPCS_CMD_ARB;
          arg     = 28'h000_0001;
          state_d = S_DONE;
        end
      S_DONE:
        if (sent)
          state_d = S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
    if (seq_error && state_q != S_IDLE)
    begin
      state_d = S_IDLE;
      load    = 1'b0;
    end
  end

  // Work count reloads per run; state is not resent mid-run, no reflush needed
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= S_IDLE;
      left_q  <= 16'h0000;
      err_q   <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == S_IDLE && start)
        left_q <= count_q;
      else if (state_q == S_WORK && load)
        left_q <= left_q - 16'h0001;
      // Hardware set wins over a software clear in the same cycle
      if (seq_error)
        err_q <= 1'b1;
      else if (wr_now && paddr == `MPCS_OFF_STATUS && pwdata[`MPCS_STAT_CLR])
        err_q <= 1'b0;
      if (state_q == S_DONE && sent)
        done_q <= 1'b1;
      else if (state_q == S_IDLE && start)
        done_q <= 1'b0;
    end
  end

  mpcs_cmd_out u_out
  (
    .clk       (clk),
    .resetn    (resetn),
    .load      (load),
    .op        (op),
    .arg       (arg),
    .busy      (busy),
    .cmd_valid (cmd_valid),
    .cmd_op    (cmd_op),
    .cmd_arg   (cmd_arg),
    .cmd_ready (cmd_ready)
  );
endmodule

/* src/mpcs_map.vh */
// Constants for the media pipe command sequencer host controller.
// Assumes a 32-bit APB register port and a valid/ready command link.
`ifndef MPCS_MAP_VH
`define MPCS_MAP_VH
`define MPCS_OFF_CTRL     12'h000
`define MPCS_OFF_STATUS   12'h004
`define MPCS_OFF_GROUP    12'h008
`define MPCS_OFF_COUNT    12'h00C
`define MPCS_OFF_SYSRT    12'h010
`define MPCS_CTRL_START   0
`define MPCS_CTRL_SELECT  1
`define MPCS_CTRL_SYSRT   2
`define MPCS_CTRL_CURBE   3
`define MPCS_CTRL_BARRIER 4
`define MPCS_CTRL_DEP     5
`define MPCS_CTRL_SYNC    6
`define MPCS_CTRL_RESET   32'h0000_0000
`define MPCS_CMD_FLUSH    4'h1
`define MPCS_CMD_SELECT   4'h2
`define MPCS_CMD_BASE     4'h3
`define MPCS_CMD_SYSRT    4'h4
`define MPCS_CMD_FECFG    4'h5
`define MPCS_CMD_CURBE    4'h6
`define MPCS_CMD_IDLOAD   4'h7
`define MPCS_CMD_GATEWAY  4'h8
`define MPCS_CMD_PERSIST  4'h9
`define MPCS_CMD_FENCE    4'hA
`define MPCS_CMD_ARB      4'hB
`define MPCS_CMD_WORK     4'hC
`define MPCS_FLAG_FEFLUSH 0
`define MPCS_FLAG_PERSIST 1
`define MPCS_STAT_CLR     6
`endif

/* src/mpcs_cmd_out.v */
// Command output stage: holds one command word until the device takes it.
// Assumes the device side accepts on cmd_valid and cmd_ready both high.
`timescale 1ns/1ps
`include "mpcs_map.vh"
module mpcs_cmd_out
(
  input  wire        clk,
  input  wire        resetn,
  input  wire        load,
  input  wire [3:0]  op,
  input  wire [27:0] arg,
  output wire        busy,
  output reg         cmd_valid,
  output reg  [3:0]  cmd_op,
  output reg  [27:0] cmd_arg,
  input  wire        cmd_ready
);
  assign busy = cmd_valid;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_valid <= 1'b0;
      cmd_op    <= 4'h0;
      cmd_arg   <= 28'h000_0000;
    end
    else if (!cmd_valid && load)
    begin
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_arg   <= arg;
    end
    else if (cmd_valid && cmd_ready)
      cmd_valid <= 1'b0;
  end
endmodule

/* tb/mpcs_chk_checker.sv */
// Order checks on the host controller's command port.
// Assumes it is bound into mpcs_host and sees only its ports.
`timescale 1ns/1ps
`include "mpcs_map.vh"
module mpcs_chk
(
  input wire        clk,
  input wire        resetn,
  input wire        cmd_valid,
  input wire [3:0]  cmd_op,
  input wire [27:0] cmd_arg,
  input wire        cmd_ready
);
  reg       any_q, base_q, fe_q, id_q, wk_q, off_q;
  reg [3:0] last_q;
  wire      acc = cmd_valid & cmd_ready;
  wire      fl  = cmd_op == `MPCS_CMD_FLUSH;
  wire      st  = cmd_op >= `MPCS_CMD_SELECT && cmd_op <= `MPCS_CMD_IDLOAD;
  // Progress flags restart at every accepted flush
  always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {any_q, base_q, fe_q, id_q, wk_q, off_q} <= 6'h00;
      last_q <= 4'h0;
    end
    else if (acc)
    begin
      any_q  <= 1'h1;
      last_q <= cmd_op;
      base_q <= !fl && (base_q || cmd_op == `MPCS_CMD_BASE);
      fe_q   <= !fl && (fe_q || cmd_op == `MPCS_CMD_FECFG);
      id_q   <= !fl && (id_q || cmd_op == `MPCS_CMD_IDLOAD);
      wk_q   <= !fl && (wk_q || cmd_op == `MPCS_CMD_WORK);
      if (cmd_op == `MPCS_CMD_ARB)
        off_q <= !cmd_arg[0];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_first; cmd_valid && !any_q |-> fl; endproperty
  a_first: assert property (p_first) else $error("first command not flush");
  property p_sel; cmd_valid && cmd_op == `MPCS_CMD_SELECT |-> last_q <= 4'h2; endproperty
  a_sel: assert property (p_sel) else $error("select out of place");
  property p_base; cmd_valid && st && cmd_op > `MPCS_CMD_BASE |-> base_q; endproperty
  a_base: assert property (p_base) else $error("state before base");
  property p_work; cmd_valid && cmd_op == `MPCS_CMD_WORK |-> fe_q && id_q; endproperty
  a_work: assert property (p_work) else $error("work before state");
  property p_nost; cmd_valid && st |-> !wk_q; endproperty
  a_nost: assert property (p_nost) else $error("state after work");
  property p_arb; cmd_valid && off_q |-> cmd_op >= `MPCS_CMD_ARB; endproperty
  a_arb: assert property (p_arb) else $error("non work with arb off");
  property p_sync; cmd_valid && cmd_op == `MPCS_CMD_WORK && cmd_arg[16]
    |-> off_q; endproperty
  a_sync: assert property (p_sync) else $error("sync item with arb on");
  property p_prt; cmd_valid && cmd_op == `MPCS_CMD_PERSIST |-> cmd_arg[1:0] == 2'h3
    && last_q == `MPCS_CMD_GATEWAY; endproperty
  a_prt: assert property (p_prt) else $error("persist item wrong");
  property p_fence; cmd_valid && cmd_op == `MPCS_CMD_FENCE
    |-> last_q == `MPCS_CMD_PERSIST; endproperty
  a_fence: assert property (p_fence) else $error("fence out of place");
  property p_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op)
    && $stable(cmd_arg); endproperty
  a_hold: assert property (p_hold) else $error("command dropped");
endmodule
bind mpcs_host mpcs_chk i_mpcs_chk (.*);

/* tb/mpcs_dev.sv */
// Device model: takes commands, keeps latest state, flags early work.
// Assumes valid/ready handshake; slow makes ready stall at random.
`timescale 1ns/1ps
`include "mpcs_map.vh"
module mpcs_dev
(
  input  wire        clk,
  input  wire        resetn,
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_op,
  input  wire [27:0] cmd_arg,
  output reg         cmd_ready,
  output reg         seq_error,
  input  wire        slow,
  input  wire        bad
);
  reg [27:0] base_q, fecfg_q, fence_q;
  reg [15:0] work_q;
  reg [7:0]  lfsr_q;
  reg [2:0]  need_q;
  wire       acc = cmd_valid & cmd_ready;
  always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {cmd_ready, seq_error, need_q, work_q} <= 21'h0;
      {base_q, fecfg_q, fence_q} <= 84'h0;
      lfsr_q <= 8'h5A;
    end
    else
    begin
      lfsr_q    <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      cmd_ready <= !slow || lfsr_q[0];
      seq_error <= bad || (acc && cmd_op == `MPCS_CMD_WORK && need_q != 3'h7);
      if (acc)
        case (cmd_op)
          `MPCS_CMD_BASE:   {base_q, need_q[0]} <= {cmd_arg, 1'h1};
          `MPCS_CMD_FECFG:  {fecfg_q, need_q[1]} <= {cmd_arg, 1'h1};
          `MPCS_CMD_IDLOAD: need_q[2] <= 1'h1;
          `MPCS_CMD_FENCE:  fence_q <= cmd_arg;
          `MPCS_CMD_WORK:   work_q <= work_q + 16'h1;
          default:          ;
        endcase
    end
endmodule

/* tb/tb_top.sv */
// Testbench: runs set up over APB, command stream checked from a queue.
// Assumes a 100 MHz clock and the device model on the command port.
`timescale 1ns/1ps
`include "mpcs_map.vh"
module tb_top;
  reg          clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0;
  reg          pwrite = 1'h0, slow = 1'h0, bad = 1'h0, mon_on = 1'h1, er;
  reg  [11:0]  paddr = 12'h0;
  reg  [31:0]  pwdata = 32'h0, rd;
  reg  [15:0]  grp;
  reg  [27:0]  sr;
  reg  [59:0]  e;
  wire [31:0]  prdata;
  wire [27:0]  cmd_arg;
  wire [3:0]   cmd_op;
  wire         pready, pslverr, cmd_valid, cmd_ready, seq_error;
  integer      bad_count = 0, checks = 0, seed = 32'hF928, n, i, k;
  logic [59:0] exp_q[$];
  always #5 clk = ~clk;
  mpcs_host i_mpcs_host (.*);
  mpcs_dev i_mpcs_dev (.*);
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task end_sim;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] ro, output logic eo);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    {ro, eo} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  function void ex(input [3:0] op, input [27:0] m, input [27:0] a);
    exp_q.push_back({m, op, a});
  endfunction
  // Polls until every expected command went out and the run stopped
  task run_wait;
    rd = 32'h20;
    for (k = 0; k < 300 && (exp_q.size() > 0 || rd[5]); k++)
      apb(1'h0, `MPCS_OFF_STATUS, 32'h0, rd, er);
    chk("left", exp_q.size(), 32'h0);
    chk("run", {31'h0, rd[5]}, 32'h0);
  endtask
  always @(posedge clk)
    if (resetn && mon_on && cmd_valid === 1'h1 && cmd_ready === 1'h1)
    begin
      e = exp_q.pop_front();
      chk("op", {28'h0, cmd_op}, {28'h0, e[31:28]});
      chk("arg", {4'h0, cmd_arg & e[59:32]}, {4'h0, e[27:0]});
    end
  initial
  begin
    #200000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    apb(1'h0, `MPCS_OFF_CTRL, 32'h0, rd, er);
    chk("ctrl", rd, `MPCS_CTRL_RESET);
    apb(1'h1, 12'h024, 32'hFFFF_FFFF, rd, er);
    chk("werr", {31'h0, er}, 32'h1);
    apb(1'h0, 12'h024, 32'h0, rd, er);
    chk("rerr", {rd[30:0], er}, 32'h1);
    sr = $random(seed);
    apb(1'h1, `MPCS_OFF_SYSRT, {4'h0, sr}, rd, er);
    apb(1'h0, `MPCS_OFF_SYSRT, 32'h0, rd, er);
    chk("sysrt", rd, {4'h0, sr});
    chk("okay", {31'h0, er}, 32'h0);
    // Every optional state step (select, sysrt, curbe), device stalling at random
    slow <= 1'h1;
    n = 1 + ($random(seed) & 3);
    apb(1'h1, `MPCS_OFF_COUNT, n, rd, er);
    for (i = 1; i < 8; i++)
      ex(i, (i == 4) ? 28'hFFF_FFFF : 28'h0, (i == 4) ? sr : 28'h0);
    for (i = 0; i < n; i++)
      ex(`MPCS_CMD_WORK, 28'h1_FFFF, n - i);
    apb(1'h1, `MPCS_OFF_CTRL, 32'hF, rd, er);
    run_wait;
    chk("done", {31'h0, rd[6]}, 32'h1);
    // Barrier group with synchronized work, prompt device
    slow <= 1'h0;
    grp = $random(seed);
    apb(1'h1, `MPCS_OFF_GROUP, {16'h0, grp}, rd, er);
    apb(1'h1, `MPCS_OFF_COUNT, 32'h4, rd, er);
    for (i = 0; i < 11; i++)
      if (i != 1 && i != 3 && i != 5)
        ex(i + 1, (i == 8) ? 28'h3 : (i == 9) ? 28'h1_FFFF : (i == 10) ? 28'h1 : 28'h0,
           (i == 8) ? 28'h3 : (i == 9) ? {12'h1, grp} : 28'h0);
    for (i = 0; i < 4; i++)
      ex(`MPCS_CMD_WORK, 28'h1_FFFF, 28'h1_0004 - i);
    ex(`MPCS_CMD_ARB, 28'h1, 28'h1);
    apb(1'h1, `MPCS_OFF_CTRL, 32'h71, rd, er);
    run_wait;
    // Synchronized items alone still bracketed by arbitration off and on
    apb(1'h1, `MPCS_OFF_COUNT, 32'h2, rd, er);
    for (i = 1; i < 8; i += 2)
      ex(i, 28'h0, 28'h0);
    ex(`MPCS_CMD_ARB, 28'h1, 28'h0);
    for (i = 0; i < 2; i++)
      ex(`MPCS_CMD_WORK, 28'h1_FFFF, 28'h1_0002 - i);
    ex(`MPCS_CMD_ARB, 28'h1, 28'h1);
    apb(1'h1, `MPCS_OFF_CTRL, 32'h41, rd, er);
    run_wait;
    // Device fault mid-run, then clear
    mon_on <= 1'h0;
    apb(1'h1, `MPCS_OFF_CTRL, 32'h1, rd, er);
    repeat (6) @(posedge clk);
    bad <= 1'h1;
    @(posedge clk);
    bad <= 1'h0;
    run_wait;
    chk("err", {31'h0, rd[7]}, 32'h1);
    apb(1'h1, `MPCS_OFF_STATUS, 32'h40, rd, er);
    apb(1'h0, `MPCS_OFF_STATUS, 32'h0, rd, er);
    chk("clr", {30'h0, rd[7], rd[5]}, 32'h0);
    end_sim;
  end
endmodule
